/* File: laser_ctrl_map.vh */
// Register offsets, field positions, reset values for the laser channel control
`ifndef LASER_CTRL_MAP_VH
`define LASER_CTRL_MAP_VH
`define ADDR_CH1_MODE 8'h10
`define ADDR_CH1_THRESH 8'h11
`define ADDR_CH2_MODE 8'h15
`define ADDR_CH2_THRESH 8'h16
`define ADDR_RANGE 8'h1a
`define ADDR_SIMULATE 8'h1d
`define ADDR_STATUS 8'h1e
`define BIT_MODE 0
`define BIT_DISABLE 3
`define BIT_RANGE_CH1 0
`define BIT_RANGE_CH2 4
`define BIT_SIM_CH1 5
`define BIT_SIM_CH2 6
`define RST_MODE 1'b0
`define RST_DISABLE 1'b1
`define RST_RANGE 1'b0
`define RST_SIM 1'b0
`define RST_THRESH 8'hff
`define THRESH_MIN 8'h0a
`endif

/* File: input_sync.v */
// Two-flip-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
module input_sync (
  input wire sys_clk_in, // System clock
  input wire rst_in, // Synchronous reset, active high
  input wire async_in, // Level from outside the clock domain
  output wire sync_out // Synchronised level
);
  reg meta_q;
  reg sync_q;
  always @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
  assign sync_out = sync_q;
endmodule // input_sync

/* File: channel_protect.v */
// Per-channel overcurrent latch, simulation forcing and enable gating
`timescale 1ns/100ps
module channel_protect (
  input wire sys_clk_in, // System clock
  input wire rst_in, // Synchronous reset, active high
  input wire enable_pin_in, // Synchronised channel enable pin
  input wire disable_bit_in, // Channel disable register bit
  input wire overcurrent_in, // Synchronised comparator trip
  input wire simulate_in, // Overcurrent simulate bit
  output wire error_flag_out, // Overcurrent error flag
  output wire channel_on_out // Channel driving permitted
);
  reg latched_q;
  reg pin_prev_q;
  wire pin_rise;
  assign pin_rise = enable_pin_in & ~pin_prev_q;
  // Real trip latches until the enable pin is cycled; set wins over clear
  always @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      latched_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end
    else
    begin
      pin_prev_q <= enable_pin_in;
      if (overcurrent_in)
        latched_q <= 1'b1;
      else if (pin_rise)
        latched_q <= 1'b0;
    end
  end
  assign error_flag_out = latched_q | simulate_in;
  assign channel_on_out = enable_pin_in & ~disable_bit_in &
    ~error_flag_out;
endmodule // channel_protect

/* File: laser_channel_mode_and_overcurrent_ctrl.v */
// Register bank and protection logic for a two-channel laser driver
`timescale 1ns/100ps
`include "laser_ctrl_map.vh"
module laser_channel_mode_and_overcurrent_ctrl (
  input wire sys_clk_in, // 40 MHz system clock
  input wire rst_in, // Synchronous reset, active high
  input wire wr_en_in, // Register write strobe from serial core
  input wire [7:0] addr_in, // Register address
  input wire [7:0] wr_data_in, // Write data
  output reg [7:0] rd_data_out, // Read data, registered
  input wire [1:0] channel_enable_pin_in, // Enable pins, async
  input wire [1:0] overcurrent_cmp_in, // Comparator trips, async
  input wire [9:0] reference_code_ch1_in, // Channel 1 reference code
  input wire [9:0] reference_code_ch2_in, // Channel 2 reference code
  output reg [9:0] ref_dac_ch1_out, // Channel 1 reference DAC code
  output reg [9:0] ref_dac_ch2_out, // Channel 2 reference DAC code
  output reg [7:0] thresh_dac_ch1_out, // Channel 1 threshold DAC code
  output reg [7:0] thresh_dac_ch2_out, // Channel 2 threshold DAC code
  output reg [1:0] thresh_low_range_out, // Threshold low range select
  output reg [1:0] reg_low_range_out, // Regulator low current range
  output reg [1:0] use_monitor_res_out, // Monitor resistor in loop
  output reg [1:0] current_mode_out, // Current control mode active
  output reg [1:0] channel_on_out, // Channel drive enable
  output reg [1:0] overcurrent_error_flag_out, // Error flags
  output reg fault_indication_pin_n_out // Fault pin, low on fault
);
  reg [1:0] control_mode_bit_q;
  reg [1:0] channel_disable_bit_q;
  reg [1:0] range_select_bit_q;
  reg [1:0] overcurrent_simulate_bit_q;
  reg [7:0] thresh_ch1_q;
  reg [7:0] thresh_ch2_q;
  wire [1:0] pin_sync;
  wire [1:0] trip_sync;
  wire [1:0] err_flag;
  wire [1:0] ch_on;
  reg [7:0] rd_d;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : gen_sync
      input_sync u_pin_sync (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .async_in(channel_enable_pin_in[g]),
        .sync_out(pin_sync[g])
      );
      input_sync u_trip_sync (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .async_in(overcurrent_cmp_in[g]),
        .sync_out(trip_sync[g])
      );
    end
  endgenerate
  channel_protect u_prot_ch1 (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .enable_pin_in(pin_sync[0]),
    .disable_bit_in(channel_disable_bit_q[0]),
    .overcurrent_in(trip_sync[0]),
    .simulate_in(overcurrent_simulate_bit_q[0]),
    .error_flag_out(err_flag[0]),
    .channel_on_out(ch_on[0])
  );
  channel_protect u_prot_ch2 (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .enable_pin_in(pin_sync[1]),
    .disable_bit_in(channel_disable_bit_q[1]),
    .overcurrent_in(trip_sync[1]),
    .simulate_in(overcurrent_simulate_bit_q[1]),
    .error_flag_out(err_flag[1]),
    .channel_on_out(ch_on[1])
  );
  // Register writes
  always @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      control_mode_bit_q <= {2{`RST_MODE}};
      channel_disable_bit_q <= {2{`RST_DISABLE}};
      range_select_bit_q <= {2{`RST_RANGE}};
      overcurrent_simulate_bit_q <= {2{`RST_SIM}};
      thresh_ch1_q <= `RST_THRESH;
      thresh_ch2_q <= `RST_THRESH;
    end
    else if (wr_en_in)
    begin
      if (addr_in == `ADDR_CH1_MODE)
      begin
        control_mode_bit_q[0] <= wr_data_in[`BIT_MODE];
        channel_disable_bit_q[0] <= wr_data_in[`BIT_DISABLE];
      end
      else if (addr_in == `ADDR_CH1_THRESH)
        thresh_ch1_q <= wr_data_in;
      else if (addr_in == `ADDR_CH2_MODE)
      begin
        control_mode_bit_q[1] <= wr_data_in[`BIT_MODE];
        channel_disable_bit_q[1] <= wr_data_in[`BIT_DISABLE];
      end
      else if (addr_in == `ADDR_CH2_THRESH)
        thresh_ch2_q <= wr_data_in;
      else if (addr_in == `ADDR_RANGE)
      begin
        range_select_bit_q[0] <= wr_data_in[`BIT_RANGE_CH1];
        range_select_bit_q[1] <= wr_data_in[`BIT_RANGE_CH2];
      end
      else if (addr_in == `ADDR_SIMULATE)
      begin
        overcurrent_simulate_bit_q[0] <= wr_data_in[`BIT_SIM_CH1];
        overcurrent_simulate_bit_q[1] <= wr_data_in[`BIT_SIM_CH2];
      end
    end
  end
  // Read mux; unmapped addresses read zero
  always @*
  begin
    rd_d = 8'h00;
    if (addr_in == `ADDR_CH1_MODE)
    begin
      rd_d[`BIT_MODE] = control_mode_bit_q[0];
      rd_d[`BIT_DISABLE] = channel_disable_bit_q[0];
    end
    else if (addr_in == `ADDR_CH1_THRESH)
      rd_d = thresh_ch1_q;
    else if (addr_in == `ADDR_CH2_MODE)
    begin
      rd_d[`BIT_MODE] = control_mode_bit_q[1];
      rd_d[`BIT_DISABLE] = channel_disable_bit_q[1];
    end
    else if (addr_in == `ADDR_CH2_THRESH)
      rd_d = thresh_ch2_q;
    else if (addr_in == `ADDR_RANGE)
    begin
      rd_d[`BIT_RANGE_CH1] = range_select_bit_q[0];
      rd_d[`BIT_RANGE_CH2] = range_select_bit_q[1];
    end
    else if (addr_in == `ADDR_SIMULATE)
    begin
      rd_d[`BIT_SIM_CH1] = overcurrent_simulate_bit_q[0];
      rd_d[`BIT_SIM_CH2] = overcurrent_simulate_bit_q[1];
    end
    else if (addr_in == `ADDR_STATUS)
      rd_d = {4'h0, ch_on, err_flag};
  end
  // Registered outputs
  always @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      rd_data_out <= 8'h00;
      ref_dac_ch1_out <= 10'h000;
      ref_dac_ch2_out <= 10'h000;
      thresh_dac_ch1_out <= `RST_THRESH;
      thresh_dac_ch2_out <= `RST_THRESH;
      thresh_low_range_out <= 2'h0;
      reg_low_range_out <= 2'h0;
      use_monitor_res_out <= 2'h3;
      current_mode_out <= 2'h0;
      channel_on_out <= 2'h0;
      overcurrent_error_flag_out <= 2'h0;
      fault_indication_pin_n_out <= 1'b1;
    end
    else
    begin
      rd_data_out <= rd_d;
      ref_dac_ch1_out <= reference_code_ch1_in;
      ref_dac_ch2_out <= reference_code_ch2_in;
      // Codes below the minimum clamp to it
      thresh_dac_ch1_out <= (thresh_ch1_q < `THRESH_MIN) ?
        `THRESH_MIN : thresh_ch1_q;
      thresh_dac_ch2_out <= (thresh_ch2_q < `THRESH_MIN) ?
        `THRESH_MIN : thresh_ch2_q;
      thresh_low_range_out <= range_select_bit_q;
      reg_low_range_out <= range_select_bit_q & control_mode_bit_q;
      use_monitor_res_out <= ~control_mode_bit_q;
      current_mode_out <= control_mode_bit_q;
      channel_on_out <= ch_on;
      overcurrent_error_flag_out <= err_flag;
      fault_indication_pin_n_out <= ~(|err_flag);
    end
  end
endmodule // laser_channel_mode_and_overcurrent_ctrl

/* File: laser_ctrl_checker_assertions.sv */
// Port assertions for the laser channel register bank
`timescale 1ns/100ps
module laser_ctrl_checker (
  input wire sys_clk_in, // Clock
  input wire rst_in, // Reset
  input wire wr_en_in, // Write strobe
  input wire [7:0] addr_in, // Address
  input wire [7:0] wr_data_in, // Write data
  input wire [1:0] overcurrent_cmp_in, // Trips
  input wire [7:0] thresh_dac_ch1_out, // Threshold code
  input wire [1:0] thresh_low_range_out, // Range
  input wire [1:0] reg_low_range_out, // Regulator range
  input wire [1:0] use_monitor_res_out, // Monitor resistor
  input wire [1:0] current_mode_out, // Mode
  input wire [1:0] channel_on_out, // Channel on
  input wire [1:0] overcurrent_error_flag_out, // Errors
  input wire fault_indication_pin_n_out // Fault pin
);
  reg [7:0] d1_q;
  reg [7:0] d2_q;
  always @(posedge sys_clk_in)
  begin
    d1_q <= wr_data_in;
    d2_q <= d1_q;
  end
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  sequence s_sim1;
    wr_en_in && addr_in == 8'h1d && wr_data_in[5];
  endsequence
  sequence s_quiet;
    !(wr_en_in && addr_in == 8'h1d) [*4];
  endsequence
  property p_sim_err;
    s_sim1 |-> ##2 overcurrent_error_flag_out[0];
  endproperty
  a_sim_err: assert property (p_sim_err)
    else $error("simulated error missing");
  property p_sim_hold;
    s_sim1 ##1 s_quiet |-> overcurrent_error_flag_out[0];
  endproperty
  a_sim_hold: assert property (p_sim_hold)
    else $error("simulated error dropped");
  property p_fault;
    fault_indication_pin_n_out == (overcurrent_error_flag_out == 2'b00);
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault pin wrong");
  property p_off;
    overcurrent_error_flag_out[0] |-> !channel_on_out[0];
  endproperty
  a_off: assert property (p_off)
    else $error("channel on with error");
  property p_trip;
    $rose(overcurrent_cmp_in[1]) |->
      ##4 overcurrent_error_flag_out[1] && !channel_on_out[1];
  endproperty
  a_trip: assert property (p_trip)
    else $error("trip not latched");
  property p_range;
    wr_en_in && addr_in == 8'h1a |->
      ##2 thresh_low_range_out == {d2_q[4], d2_q[0]};
  endproperty
  a_range: assert property (p_range)
    else $error("range bits wrong");
  property p_thr;
    wr_en_in && addr_in == 8'h11 |->
      ##2 thresh_dac_ch1_out == (d2_q < 8'h0a ? 8'h0a : d2_q);
  endproperty
  a_thr: assert property (p_thr)
    else $error("threshold code wrong");
  property p_mode;
    wr_en_in && addr_in == 8'h10 |-> ##2 current_mode_out[0] == d2_q[0];
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode bit wrong");
  property p_reg;
    reg_low_range_out == (thresh_low_range_out & current_mode_out);
  endproperty
  a_reg: assert property (p_reg)
    else $error("regulator range wrong");
  property p_mon;
    use_monitor_res_out == ~current_mode_out;
  endproperty
  a_mon: assert property (p_mon)
    else $error("monitor resistor wrong");
  property p_rst;
    $fell(rst_in) |-> thresh_dac_ch1_out == 8'hff &&
      overcurrent_error_flag_out == 2'b00 && fault_indication_pin_n_out;
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset values wrong");
endmodule // laser_ctrl_checker
bind laser_channel_mode_and_overcurrent_ctrl laser_ctrl_checker u_chk (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .wr_en_in(wr_en_in),
  .addr_in(addr_in), .wr_data_in(wr_data_in),
  .overcurrent_cmp_in(overcurrent_cmp_in),
  .thresh_dac_ch1_out(thresh_dac_ch1_out),
  .thresh_low_range_out(thresh_low_range_out),
  .reg_low_range_out(reg_low_range_out),
  .use_monitor_res_out(use_monitor_res_out),
  .current_mode_out(current_mode_out), .channel_on_out(channel_on_out),
  .overcurrent_error_flag_out(overcurrent_error_flag_out),
  .fault_indication_pin_n_out(fault_indication_pin_n_out)
);

/* File: mcu_model.sv */
// Microcontroller model driving the register write and read port
`timescale 1ns/100ps
module mcu_model (
  input wire sys_clk_in, // Clock
  output reg wr_en_out, // Write strobe
  output reg [7:0] addr_out, // Address
  output reg [7:0] wr_data_out, // Write data
  output reg rd_stb_out // Read issued
);
  initial
  begin
    wr_en_out = 1'b0;
    addr_out = 8'h00;
    wr_data_out = 8'h00;
    rd_stb_out = 1'b0;
  end
  task wr_reg(input [7:0] a, input [7:0] d);
  begin
    @(posedge sys_clk_in);
    wr_en_out <= 1'b1;
    addr_out <= a;
    wr_data_out <= d;
    @(posedge sys_clk_in);
    wr_en_out <= 1'b0;
    wr_data_out <= ~d;
  end
  endtask
  task rd_reg(input [7:0] a);
  begin
    @(posedge sys_clk_in);
    addr_out <= a;
    rd_stb_out <= 1'b1;
    @(posedge sys_clk_in);
    rd_stb_out <= 1'b0;
    @(posedge sys_clk_in);
  end
  endtask
endmodule // mcu_model

/* File: laser_channel_mode_and_overcurrent_ctrl_tb_top.sv */
// Self-checking bench for the laser channel register bank
`timescale 1ns/100ps
module laser_channel_mode_and_overcurrent_ctrl_tb_top;
  reg sys_clk = 1'b0;
  reg rst = 1'b1;
  reg [1:0] en_pin = 2'b00;
  reg [1:0] trip = 2'b00;
  reg [9:0] ref1 = 10'h000;
  reg [9:0] ref2 = 10'h000;
  reg stb_d = 1'b0;
  reg [7:0] exp_q[$];
  reg [7:0] v;
  reg [7:0] a;
  integer r;
  integer i;
  integer bad_count = 0;
  integer samples_checked = 0;
  wire wr_en, rd_stb, fault_n;
  wire [7:0] addr, wr_data, rd_data, th1, th2;
  wire [9:0] dac1, dac2;
  wire [1:0] th_lo, reg_lo, mon, mode, on, err;
  always #12.5 sys_clk = ~sys_clk;
  mcu_model mcu (.sys_clk_in(sys_clk), .wr_en_out(wr_en),
    .addr_out(addr), .wr_data_out(wr_data), .rd_stb_out(rd_stb));
  laser_channel_mode_and_overcurrent_ctrl dut (
    .sys_clk_in(sys_clk), .rst_in(rst), .wr_en_in(wr_en),
    .addr_in(addr), .wr_data_in(wr_data), .rd_data_out(rd_data),
    .channel_enable_pin_in(en_pin), .overcurrent_cmp_in(trip),
    .reference_code_ch1_in(ref1), .reference_code_ch2_in(ref2),
    .ref_dac_ch1_out(dac1), .ref_dac_ch2_out(dac2),
    .thresh_dac_ch1_out(th1), .thresh_dac_ch2_out(th2),
    .thresh_low_range_out(th_lo), .reg_low_range_out(reg_lo),
    .use_monitor_res_out(mon), .current_mode_out(mode),
    .channel_on_out(on), .overcurrent_error_flag_out(err),
    .fault_indication_pin_n_out(fault_n));
  task chk(input [9:0] got, input [9:0] exp);
  begin
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task finish_test;
  begin
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  task rd(input [7:0] ad, input [7:0] e);
  begin
    exp_q.push_back(e);
    mcu.rd_reg(ad);
  end
  endtask
  // Fault pin, error flags and channel enables as one word
  task see(input integer n, input [9:0] e);
  begin
    repeat (n) @(posedge sys_clk);
    #1;
    chk({5'h00, fault_n, err, on}, e);
    @(posedge sys_clk);
  end
  endtask
  always @(posedge sys_clk) stb_d <= rd_stb;
  always @(negedge sys_clk)
    if (stb_d)
      chk({2'b00, rd_data}, {2'b00, exp_q.pop_front()});
  initial
  begin
    #100000;
    bad_count = bad_count + 1;
    finish_test;
  end
  initial
  begin
    r = $urandom(41);
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    see(1, 10'h010);
    rd(8'h11, 8'hff);
    rd(8'h16, 8'hff);
    rd(8'h1a, 8'h00);
    rd(8'h1d, 8'h00);
    rd(8'h10, 8'h08);
    rd(8'h05, 8'h00);
    for (i = 0; i < 4; i = i + 1)
    begin
      r = $urandom;
      v = (r[7:0] < 8'h0a) ? 8'h0a : r[7:0];
      a = i[0] ? 8'h16 : 8'h11;
      mcu.wr_reg(a, v);
      rd(a, v);
    end
    chk({2'b00, th2}, {2'b00, v});
    mcu.wr_reg(8'h11, 8'h03);
    rd(8'h11, 8'h03);
    chk({2'b00, th1}, 10'h00a);
    r = $urandom;
    ref1 <= r[9:0];
    ref2 <= r[19:10];
    mcu.wr_reg(8'h1a, 8'h11);
    rd(8'h1a, 8'h11);
    chk(dac1, ref1);
    chk(dac2, ref2);
    chk({6'h00, th_lo, reg_lo}, 10'h00c);
    mcu.wr_reg(8'h10, 8'h01);
    mcu.wr_reg(8'h15, 8'h01);
    rd(8'h15, 8'h01);
    chk({4'h0, mode, reg_lo, mon}, 10'h03c);
    en_pin <= 2'b11;
    see(6, 10'h013);
    mcu.wr_reg(8'h1d, 8'h20);
    see(2, 10'h006);
    see(5, 10'h006);
    mcu.wr_reg(8'h1d, 8'h40);
    see(4, 10'h009);
    mcu.wr_reg(8'h1d, 8'h00);
    see(4, 10'h013);
    trip <= 2'b10;
    see(6, 10'h009);
    trip <= 2'b00;
    see(6, 10'h009);
    rd(8'h1e, 8'h06);
    en_pin <= 2'b01;
    see(6, 10'h009);
    en_pin <= 2'b11;
    see(8, 10'h013);
    rd(8'h1e, 8'h0c);
    finish_test;
  end
endmodule // laser_channel_mode_and_overcurrent_ctrl_tb_top
